// ==== rtl/ebt_timer.sv ====
// Contract
// - The count is eight bits, wraps from FFh to 00h and each wrap is an overflow event.
// - With clock source select clear and no prescaler, the count advances every cycle.
// - A software write to the count blocks counting for the next two cycles.
// - With clock source select set, the count advances on external input edges.
// - Source edge select clear counts rising edges, set counts falling edges.
// - An 8-bit programmable prescaler is shared with the watchdog and assigned to one user.
// - Overflow sets the flag; interrupt only while enabled; software clears the flag.
// - The counter stops during sleep, so its overflow cannot wake the core.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ebt_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sleep_i,
   input wire logic ext_count_i,
   input wire logic wdt_tick_i,
   output logic wdt_tc_o,
   output logic irq_o,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [7:0] count_r;
   logic [7:0] option_r;
   logic [7:0] irqctl_r;
   logic [1:0] inhibit_r;
   logic [3:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic w_have_r;
   logic w_strb_r;
   logic psc_tc;
   logic ext_edge;
   logic wdt_tc_int;
   ebt_pkg::ebt_opt_s opt;

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == ebt_pkg::ADDR_COUNT) || (a == ebt_pkg::ADDR_OPTION)
         || (a == ebt_pkg::ADDR_STATUS) || (a == ebt_pkg::ADDR_MASK);
   endfunction

   assign opt = ebt_pkg::ebt_opt_s'(option_r[5:0]);

   // Core ticks: stopped in sleep
   wire run = ce_i & ~sleep_i;
   wire src_tick = opt.cs ? ext_edge : 1'b1;
   wire psc_to_tmr = ~opt.psa;
   wire psc_in = psc_to_tmr ? (src_tick & ~sleep_i) : wdt_tick_i;
   wire tmr_tick = psc_to_tmr ? psc_tc : src_tick;

   // Write channel
   wire aw_ok = s_axi_awvalid & s_axi_awready;
   wire w_ok = s_axi_wvalid & s_axi_wready;
   wire aw_in_range = (s_axi_awaddr[31:4] == 28'h0);
   wire [3:0] wa = aw_have_r ? aw_addr_r : s_axi_awaddr[3:0];
   wire [31:0] wd = w_have_r ? w_data_r : s_axi_wdata;
   // Strobe kept with data taken ahead of the address
   wire ws = w_have_r ? w_strb_r : s_axi_wstrb[0];
   wire wa_ok = aw_have_r | aw_in_range;
   wire wr_go = (aw_have_r | aw_ok) & (w_have_r | w_ok) & ~s_axi_bvalid;
   wire wr_en = wr_go & ws & wa_ok;
   wire wr_count = wr_en & (wa == ebt_pkg::ADDR_COUNT);
   wire wr_option = wr_en & (wa == ebt_pkg::ADDR_OPTION);
   wire wr_mask = wr_en & (wa == ebt_pkg::ADDR_MASK);
   wire [1:0] wr_resp = mapped(wa) && wa_ok ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;

   // Read channel
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire [3:0] ra = s_axi_araddr[3:0];
   wire ar_in_range = (s_axi_araddr[31:4] == 28'h0);
   wire rd_status = rd_go & ar_in_range & (ra == ebt_pkg::ADDR_STATUS);
   wire [7:0] rd_sel = (ra == ebt_pkg::ADDR_COUNT) ? count_r :
      (ra == ebt_pkg::ADDR_OPTION) ? option_r :
      (ra == ebt_pkg::ADDR_STATUS) ? irqctl_r :
      (ra == ebt_pkg::ADDR_MASK) ? irqctl_r : 8'h00;
   // Out-of-range addresses alias nothing and read as zero
   wire [7:0] rd_mux = ar_in_range ? rd_sel : 8'h00;
   wire [1:0] rd_resp = mapped(ra) && ar_in_range ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;

   // Count path
   wire can_count = run & (inhibit_r == 2'h0) & tmr_tick;
   wire ovf = can_count & (count_r == ebt_pkg::COUNT_MAX);
   wire [7:0] count_nxt = wr_count ? wd[7:0] : (can_count ? count_r + 8'h01 : count_r);

   // Flag: set wins over clear
   logic flag_nxt;
   always_comb begin
      flag_nxt = irqctl_r[ebt_pkg::IRQ_FLAG_BIT];
      if (rd_status) begin
         flag_nxt = 1'b0;
      end
      if (wr_mask) begin
         flag_nxt = wd[ebt_pkg::IRQ_FLAG_BIT];
      end
      if (ovf) begin
         flag_nxt = 1'b1;
      end
   end

   ebt_prescaler u_psc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clr_i(wr_count | wr_option),
      .tick_i(psc_in),
      .rate_i(opt.ps),
      .tc_o(psc_tc)
   );

   ebt_edge_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(run),
      .pin_i(ext_count_i),
      .fall_sel_i(opt.se),
      .edge_o(ext_edge)
   );

   assign wdt_tc_int = ~psc_to_tmr ? psc_tc : wdt_tick_i;

   // Write reloads the hold-off, which drains only while the core runs
   wire [1:0] inhibit_nxt = wr_count ? ebt_pkg::INHIBIT_CYCLES :
      ((inhibit_r != 2'h0) && run) ? inhibit_r - 2'h1 : inhibit_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_r <= ebt_pkg::COUNT_ZERO;
      end else if (ce_i) begin
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inhibit_r <= 2'h0;
      end else if (ce_i) begin
         inhibit_r <= inhibit_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         option_r <= ebt_pkg::OPTION_RST;
      end else if (ce_i) begin
         if (wr_option) begin
            option_r <= wd[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irqctl_r <= 8'h00;
      end else if (ce_i) begin
         if (wr_mask) begin
            irqctl_r[7:3] <= wd[7:3];
            irqctl_r[1:0] <= wd[1:0];
         end
         irqctl_r[ebt_pkg::IRQ_FLAG_BIT] <= flag_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         wdt_tc_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= flag_nxt & irqctl_r[ebt_pkg::IRQ_EN_BIT];
         wdt_tc_o <= wdt_tc_int;
      end
   end

   // AXI4-Lite write address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_awready <= 1'b0;
         aw_have_r <= 1'b0;
         aw_addr_r <= 4'h0;
      end else if (ce_i) begin
         s_axi_awready <= ~aw_have_r & ~aw_ok & ~s_axi_bvalid;
         if (wr_go) begin
            aw_have_r <= 1'b0;
         end else if (aw_ok) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= aw_in_range ? s_axi_awaddr[3:0] : 4'h1;
         end
      end
   end

   // AXI4-Lite write data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_wready <= 1'b0;
         w_have_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 1'b0;
      end else if (ce_i) begin
         s_axi_wready <= ~w_have_r & ~w_ok & ~s_axi_bvalid;
         if (wr_go) begin
            w_have_r <= 1'b0;
         end else if (w_ok) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb[0];
         end
      end
   end

   // AXI4-Lite write response
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ebt_pkg::RESP_OKAY;
      end else if (ce_i) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_arready <= 1'b0;
      end else if (ce_i) begin
         s_axi_arready <= ~s_axi_rvalid & ~rd_go;
      end
   end

   // AXI4-Lite read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ebt_pkg::RESP_OKAY;
      end else if (ce_i) begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_mux};
            s_axi_rresp <= rd_resp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // ebt_timer
`default_nettype wire

// ==== rtl/ebt_pkg.sv ====
package ebt_pkg;
   localparam logic [3:0] ADDR_COUNT = 4'h0;
   localparam logic [3:0] ADDR_OPTION = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_MASK = 4'hC;
   localparam int OPT_PSA_BIT = 3;
   localparam int OPT_SE_BIT = 4;
   localparam int OPT_CS_BIT = 5;
   localparam int IRQ_FLAG_BIT = 2;
   localparam int IRQ_EN_BIT = 5;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic cs;
      logic se;
      logic psa;
      logic [2:0] ps;
   } ebt_opt_s;
endpackage

// ==== rtl/ebt_edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebt_edge_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic pin_i,
   input wire logic fall_sel_i,
   output logic edge_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   wire rise = s2_r & ~s3_r;
   wire fall = ~s2_r & s3_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         edge_o <= 1'b0;
      end else if (ce_i) begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         edge_o <= fall_sel_i ? fall : rise;
      end
   end
endmodule // ebt_edge_sync
`default_nettype wire

// ==== rtl/ebt_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebt_prescaler (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic clr_i,
   input wire logic tick_i,
   input wire logic [2:0] rate_i,
   output logic tc_o
);
   logic [7:0] cnt_r;
   wire [7:0] mask = 8'(({1'b0, 8'h01} << (4'(rate_i) + 4'h1)) - 9'h001);
   wire [7:0] cnt_nxt = cnt_r + 8'h01;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 8'h00;
         tc_o <= 1'b0;
      end else if (ce_i) begin
         tc_o <= 1'b0;
         if (clr_i) begin
            cnt_r <= 8'h00;
         end else if (tick_i) begin
            cnt_r <= cnt_nxt;
            tc_o <= ((cnt_nxt & mask) == 8'h00);
         end
      end
   end
endmodule // ebt_prescaler
`default_nettype wire

// ==== tb/ebt_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebt_pin_model (
   input wire logic clk_i,
   output logic pin_o
);
   initial pin_o = 1'b0;
   // Levels held at least four cycles so the synchroniser sees each one
   task automatic edges(input int n);
      repeat (n) begin
         @(posedge clk_i) pin_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         pin_o <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      pin_o <= 1'b1;
   endtask
   task automatic park();
      @(posedge clk_i) pin_o <= 1'b0;
   endtask
endmodule // ebt_pin_model
`default_nettype wire

// ==== tb/ebt_timer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sleep_i,
   input wire logic irq_o,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic aw_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire logic ar_hit = s_axi_arvalid && s_axi_arready;
   AST_B_ANSWER: assert property (aw_hit |=> s_axi_bvalid) else $error("write answer late");
   AST_R_ANSWER: assert property (ar_hit |=> s_axi_rvalid) else $error("read answer late");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
   AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
   AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready early");
   AST_R_ERR: assert property (ar_hit && s_axi_araddr > 32'hC |=> s_axi_rdata == 32'h0
      && s_axi_rresp == ebt_pkg::RESP_SLVERR) else $error("unmapped read answered");
   AST_IRQ_CLR: assert property (ar_hit && s_axi_araddr == 32'h8 && sleep_i |=> ##[1:3] !irq_o)
      else $error("irq kept after status read");
   cover property (aw_hit);
   cover property ($rose(irq_o));
   cover property (ar_hit && s_axi_araddr == 32'h8);
endmodule // ebt_timer_asserts
bind ebt_timer ebt_timer_asserts ebt_timer_asserts_i (.*);
`default_nettype wire

// ==== tb/ebt_timer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_bench;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, sleep_i = 1'b0, wdt_tick_i = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic irq_o, wdt_tc_o, ext_count_i;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] w, v;
   int num_errors = 0, checks = 0, cyc = 0, tcs = 0, tw, tr, t1, n, seed = 32'h2438;
   ebt_timer ebt_timer_i (.*);
   ebt_pin_model ebt_pin_model_i (.clk_i(clk_i), .pin_o(ext_count_i));
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   always @(posedge clk_i) tcs <= tcs + int'(wdt_tc_o);
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] x);
      logic aw_p, w_p;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      while (aw_p || w_p) begin
         @(posedge clk_i);
         tw = cyc;
         if (aw_p && s_axi_awready) begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_p && s_axi_wready) begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_i); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready);
      tr = cyc;
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      num_errors++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(32'h4);
      chk("option", 32'hFF, d);
      rd(32'hC);
      chk("control", 32'h0, d);
      wr(32'h4, 32'h08);
      chk("write resp", ebt_pkg::RESP_OKAY, r);
      repeat (3) begin
         w = $random(seed);
         wr(32'h0, {24'h0, w});
         rd(32'h0);
         t1 = tr;
         v = d[7:0];
         chk("count after write", 8'(w + tr - tw - 3), d);
         rd(32'h0);
         chk("free count", 8'(v + tr - t1), d);
      end
      t1 = tr;
      v = d[7:0];
      ce_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce_i <= 1'b1;
      rd(32'h0);
      chk("frozen count", 8'(v + tr - t1 - 10), d);
      sleep_i <= 1'b1;
      wr(32'h0, 32'h5A);
      repeat (6) @(posedge clk_i);
      rd(32'h0);
      chk("asleep", 32'h5A, d);
      sleep_i <= 1'b0;
      wr(32'hC, 32'h20);
      wr(32'h0, 32'hFE);
      repeat (8) @(posedge clk_i);
      chk("irq raised", 1, irq_o);
      sleep_i <= 1'b1;
      rd(32'h8);
      chk("status", 32'h24, d);
      repeat (4) @(posedge clk_i);
      chk("irq cleared", 0, irq_o);
      wr(32'hC, 32'h0);
      sleep_i <= 1'b0;
      wr(32'h0, 32'hFE);
      repeat (8) @(posedge clk_i);
      chk("irq masked", 0, irq_o);
      rd(32'h8);
      chk("flag only", 32'h04, d);
      for (int se = 0; se < 2; se++) begin
         ebt_pin_model_i.park();
         repeat (8) @(posedge clk_i);
         wr(32'h4, se ? 32'h38 : 32'h28);
         wr(32'h0, 32'h0);
         n = ($random(seed) & 32'hF) + 1;
         ebt_pin_model_i.edges(n);
         repeat (8) @(posedge clk_i);
         rd(32'h0);
         chk("edges", n + 1 - se, d);
      end
      wr(32'h4, 32'h00);
      rd(32'h0);
      t1 = tr;
      v = d[7:0];
      repeat (40) @(posedge clk_i);
      rd(32'h0);
      n = 8'(d[7:0] - v) - (tr - t1) / 2;
      chk("prescaled", 1, n >= -1 && n <= 1);
      wr(32'h4, 32'h08);
      t1 = tcs;
      repeat (20) begin
         @(posedge clk_i) wdt_tick_i <= 1'b1;
         @(posedge clk_i) wdt_tick_i <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      chk("watchdog terminals", 10, tcs - t1);
      rd(32'h10);
      chk("unmapped data", 32'h0, d);
      chk("unmapped read", ebt_pkg::RESP_SLVERR, r);
      wr(32'h14, 32'h55);
      chk("unmapped write", ebt_pkg::RESP_SLVERR, r);
      close_out();
   end
endmodule // ebt_timer_bench
`default_nettype wire
